// ---- inc/rbl_map.vh ----
// Constants for the reset boot loader sequencer
// Operation
// - Boot pins 00 external run, 01 parallel flash, 10 SPI host, 11 serial memory.
// - Boot pins are captured at power-on reset and at software reset.
// - External run skips loading and starts fetch at 0x2000_0000, 16-bit packing.
// - External memory timing defaults to 4 setup, 15 access, 3 hold cycles.
// - Parallel flash loading reads through asynchronous memory bank 0.
// - Serial memory mode: drive select, send read command, 0x00 address bytes until detected.
// - Detected serial memory data is written to instruction memory from lowest address.
// - SPI host mode: device is slave, host master sends the image bytes.
// - Wait pin asserted while busy; host sends nothing more until it drops.
// - Header flag bits 8 to 5 select which GPIO acts as wait pin.
// - Every loading mode first reads a 10-byte header: count and destination.
// - Many blocks per boot; after the last, execution starts at instruction memory base.
// - Software reset with config bit 4 set skips boot, jumps to memory base.
// - Leaving hibernate by wakeup or reset pin starts a new boot sequence.
`ifndef RBL_MAP_VH
`define RBL_MAP_VH
`define RBL_MODE_EXT      2'h0
`define RBL_MODE_PFLASH   2'h1
`define RBL_MODE_SPIHOST  2'h2
`define RBL_MODE_SPIMEM   2'h3
`define RBL_EXT_START     32'h20000000
`define RBL_IMEM_START    32'h00010000 // Instruction memory base, a free choice
`define RBL_BANK0_BASE    32'h20000000
`define RBL_SETUP_CYC     4'h4
`define RBL_ACCESS_CYC    4'hF
`define RBL_HOLD_CYC      4'h3
`define RBL_HDR_BYTES     4'hA
`define RBL_SPI_READ_CMD  8'h03
`define RBL_ADDR_FILL     8'h00
`define RBL_MAX_ADDR_B    2'h3
`define RBL_CFG_NOBOOT    4
`define RBL_FLAG_WAIT_LO  5
`define RBL_FLAG_LAST     15
`define RBL_SCK_HALF      4'h4
`endif

// ---- src/rbl_sequencer.v ----
// Reset boot loader sequencer: mode decode, header parsing and block loading
`timescale 1ns/10ps
`include "rbl_map.vh"

module rbl_sequencer (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Reset sources, boot pins and skip flag set
  input  wire        por_event,
  input  wire        sw_reset,
  input  wire        hib_wake,
  input  wire [1:0]  boot_select_pins,
  input  wire        cfg_noboot_set,
  // Parallel flash (bank 0)
  output reg  [31:0] pf_addr_q,
  output reg         pf_rd_q,
  input  wire [7:0]  pf_data,
  input  wire        pf_ack,
  // SPI master to serial memory
  output reg         serial_memory_select_flag_q,
  output reg         msck_q,
  output reg         mosi_q,
  input  wire        miso,
  // SPI slave from host
  input  wire        ssck,
  input  wire        ssel_n,
  input  wire        smosi,
  output reg  [15:0] host_wait_pin_q,
  // Instruction memory write
  output reg  [31:0] mem_addr_q,
  output reg  [7:0]  mem_data_q,
  output reg         mem_we_q,
  input  wire        mem_ready,
  // Status
  output reg  [31:0] fetch_addr_q,
  output reg         fetch_go_q,
  output reg         ext_pack16_q,
  output reg  [3:0]  amc_setup_q,
  output reg  [3:0]  amc_access_q,
  output reg  [3:0]  amc_hold_q,
  output reg  [4:0]  reset_cfg_q,
  output reg         boot_busy_q,
  output reg         spi_fail_q
);

  // States
  localparam ST_IDLE = 9'h001;
  localparam ST_DEC  = 9'h002;
  localparam ST_CMD  = 9'h004;
  localparam ST_PROB = 9'h008;
  localparam ST_HDR  = 9'h010;
  localparam ST_DATA = 9'h020;
  localparam ST_NEXT = 9'h040;
  localparam ST_RUN  = 9'h080;
  localparam ST_ERR  = 9'h100;

  reg [8:0]  st_q;
  reg [1:0]  pin_s1_q, pin_s2_q;
  reg [2:0]  ssck_s_q, ssel_s_q, smosi_s_q, miso_s_q;
  reg        start_q;
  reg [79:0] hdr_q;
  reg [3:0]  hcnt_q;
  reg [31:0] bcnt_q;
  reg [1:0]  abytes_q;
  reg [2:0]  bit_q;
  reg [7:0]  sh_q;
  reg        got_q;
  reg [7:0]  got_byte_q;
  reg [3:0]  sck_div_q;
  reg        mx_busy_q;
  reg [7:0]  mx_tx_q;
  reg [7:0]  srx_q;
  reg [2:0]  sbit_q;
  // Two-entry buffer between source and memory
  reg [7:0]  fb_d0_q, fb_d1_q;
  reg [1:0]  fb_n_q;
  // A word offered while full would be lost: sources wait on src_ok, the host on its wait pin
  wire       fb_full  = (fb_n_q == 2'h2);
  wire       fb_empty = (fb_n_q == 2'h0);
  wire       fb_push  = got_q && (st_q == ST_DATA);
  wire       fb_pop   = !fb_empty && (!mem_we_q || mem_ready);
  wire       ssck_rise = ssck_s_q[1] && !ssck_s_q[2];
  wire       mode_host = (reset_cfg_q[1:0] == `RBL_MODE_SPIHOST);
  wire       loading   = (st_q == ST_HDR) || (st_q == ST_DATA);
  // Source may only produce while buffer has room
  wire       src_ok = !fb_full && !got_q;
  // First byte of a serial exchange: read command, then zero address fill
  wire [7:0] mx_first = (st_q == ST_CMD) ? `RBL_SPI_READ_CMD : `RBL_ADDR_FILL;

  // Input synchronisers
  // Logic reads only the later stages; the first stage feeds nothing but the second
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_q  <= 2'h0;
      pin_s2_q  <= 2'h0;
      ssck_s_q  <= 3'h0;
      ssel_s_q  <= 3'h7;
      smosi_s_q <= 3'h0;
      miso_s_q  <= 3'h0;
    end else begin
      pin_s1_q  <= boot_select_pins;
      pin_s2_q  <= pin_s1_q;
      ssck_s_q  <= {ssck_s_q[1:0], ssck};
      ssel_s_q  <= {ssel_s_q[1:0], ssel_n};
      smosi_s_q <= {smosi_s_q[1:0], smosi};
      miso_s_q  <= {miso_s_q[1:0], miso};
    end
  end

  // Byte sources: host slave shifter, parallel flash, serial master
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      srx_q      <= 8'h00;
      sbit_q     <= 3'h0;
      got_q      <= 1'b0;
      got_byte_q <= 8'h00;
      pf_addr_q  <= 32'h00000000;
      pf_rd_q    <= 1'b0;
      msck_q     <= 1'b0;
      mosi_q     <= 1'b0;
      sck_div_q  <= 4'h0;
      mx_busy_q  <= 1'b0;
      mx_tx_q    <= 8'h00;
      sh_q       <= 8'h00;
      bit_q      <= 3'h0;
    end else begin
      got_q <= 1'b0;
      if (start_q) begin
        sbit_q    <= 3'h0;
        pf_addr_q <= `RBL_BANK0_BASE;
        pf_rd_q   <= 1'b0;
        mx_busy_q <= 1'b0;
        msck_q    <= 1'b0;
      end else if (mode_host) begin
        if (ssel_s_q[2]) begin
          sbit_q <= 3'h0;
        end else if (ssck_rise && loading) begin
          srx_q  <= {srx_q[6:0], smosi_s_q[2]};
          sbit_q <= sbit_q + 3'h1;
          if (sbit_q == 3'h7) begin
            got_q      <= 1'b1;
            got_byte_q <= {srx_q[6:0], smosi_s_q[2]};
          end
        end
      end else if (reset_cfg_q[1:0] == `RBL_MODE_PFLASH) begin
        if (pf_rd_q && pf_ack) begin
          pf_rd_q    <= 1'b0;
          got_q      <= 1'b1;
          got_byte_q <= pf_data;
          pf_addr_q  <= pf_addr_q + 32'h1;
        end else if (!pf_rd_q && loading && src_ok) begin
          pf_rd_q <= 1'b1;
        end
      end else if (mx_busy_q) begin
        // Serial master byte exchange, mode 0
        // Miso is taken as the clock rises, mosi moves as it falls
        if (sck_div_q == `RBL_SCK_HALF) begin
          sck_div_q <= 4'h0;
          msck_q    <= !msck_q;
          if (!msck_q) begin
            sh_q <= {sh_q[6:0], miso_s_q[2]};
          end else begin
            bit_q <= bit_q + 3'h1;
            mosi_q  <= mx_tx_q[6];
            mx_tx_q <= {mx_tx_q[6:0], 1'b0};
            if (bit_q == 3'h7) begin
              mx_busy_q  <= 1'b0;
              got_q      <= 1'b1;
              got_byte_q <= sh_q;
            end
          end
        end else begin
          sck_div_q <= sck_div_q + 4'h1;
        end
      end else if (serial_memory_select_flag_q == 1'b0 && src_ok &&
                   (st_q == ST_CMD || st_q == ST_PROB || loading)) begin
        // next byte: command, zero address fill or dummy
        mx_busy_q <= 1'b1;
        bit_q     <= 3'h0;
        sck_div_q <= 4'h0;
        mosi_q    <= mx_first[7];
        mx_tx_q   <= mx_first;
      end
    end
  end

  // Main sequencer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q          <= ST_IDLE;
      start_q       <= 1'b0;
      reset_cfg_q   <= 5'h00;
      fetch_addr_q  <= 32'h00000000;
      fetch_go_q    <= 1'b0;
      ext_pack16_q  <= 1'b0;
      amc_setup_q   <= `RBL_SETUP_CYC;
      amc_access_q  <= `RBL_ACCESS_CYC;
      amc_hold_q    <= `RBL_HOLD_CYC;
      boot_busy_q   <= 1'b0;
      spi_fail_q    <= 1'b0;
      serial_memory_select_flag_q <= 1'b1;
      host_wait_pin_q <= 16'h0000;
      hdr_q    <= 80'h0;
      hcnt_q   <= 4'h0;
      bcnt_q   <= 32'h0;
      abytes_q <= 2'h0;
    end else begin
      start_q <= 1'b0;
      if (por_event || hib_wake || sw_reset) begin
        fetch_go_q  <= 1'b0;
        reset_cfg_q[1:0] <= pin_s2_q;
        if (por_event || hib_wake) begin
          reset_cfg_q[`RBL_CFG_NOBOOT] <= 1'b0;
        end
        if (sw_reset && !por_event && !hib_wake && reset_cfg_q[`RBL_CFG_NOBOOT]) begin
          st_q <= ST_RUN;
          fetch_addr_q <= `RBL_IMEM_START;
        end else begin
          st_q        <= ST_DEC;
          start_q     <= 1'b1;
          boot_busy_q <= 1'b1;
        end
      end else begin
        case (st_q)
          // Nothing happens until a reset event arrives
          ST_IDLE: st_q <= ST_IDLE;
          ST_DEC: begin
            amc_setup_q  <= `RBL_SETUP_CYC;
            amc_access_q <= `RBL_ACCESS_CYC;
            amc_hold_q   <= `RBL_HOLD_CYC;
            hcnt_q <= 4'h0;
            ext_pack16_q <= 1'b0;
            case (reset_cfg_q[1:0])
              `RBL_MODE_EXT: begin
                ext_pack16_q <= 1'b1;
                fetch_addr_q <= `RBL_EXT_START;
                st_q <= ST_RUN;
              end
              `RBL_MODE_SPIMEM: begin
                serial_memory_select_flag_q <= 1'b0;
                abytes_q <= 2'h0;
                st_q <= ST_CMD;
              end
              default: st_q <= ST_HDR;
            endcase
          end
          ST_CMD: if (got_q) st_q <= ST_PROB;
          ST_PROB: if (got_q) begin
            // probe: a non-ones reply after the fill marks detection
            if (abytes_q != 2'h0 && got_byte_q != 8'hFF) begin
              st_q <= ST_HDR;
            end else if (abytes_q == `RBL_MAX_ADDR_B) begin
              st_q <= ST_ERR;
            end else begin
              abytes_q <= abytes_q + 2'h1;
            end
          end
          ST_HDR: if (got_q) begin
            hdr_q  <= {got_byte_q, hdr_q[79:8]};
            hcnt_q <= hcnt_q + 4'h1;
            if (hcnt_q == `RBL_HDR_BYTES - 4'h1) begin
              hcnt_q <= 4'h0;
              // Count sits in bytes 4 to 7; the last flag byte is still arriving
              bcnt_q <= hdr_q[71:40];
              st_q   <= (hdr_q[71:40] == 32'h0) ? ST_NEXT : ST_DATA;
            end
          end
          ST_DATA: if (fb_push) begin
            bcnt_q <= bcnt_q - 32'h1;
            if (bcnt_q == 32'h1) st_q <= ST_NEXT;
          end
          ST_NEXT: if (fb_empty && !mem_we_q) begin
            st_q <= hdr_q[72 + `RBL_FLAG_LAST - 8] ? ST_RUN : ST_HDR;
            fetch_addr_q <= `RBL_IMEM_START;
          end
          ST_RUN: begin
            serial_memory_select_flag_q <= 1'b1;
            fetch_go_q  <= 1'b1;
            boot_busy_q <= 1'b0;
          end
          // No device answered: select released, fail flag stays until reset
          ST_ERR: begin
            serial_memory_select_flag_q <= 1'b1;
            spi_fail_q <= 1'b1;
          end
          default: st_q <= ST_IDLE;
        endcase
      end
      // Software setting of the skip flag wins over a clearing event
      if (cfg_noboot_set) begin
        reset_cfg_q[`RBL_CFG_NOBOOT] <= 1'b1;
      end
      // wait pin selection, busy wait, held while committing
      // Until a header is in, the index is whatever the last header held
      host_wait_pin_q <= 16'h0000;
      if (mode_host && boot_busy_q && (fb_full || st_q == ST_NEXT || st_q == ST_DEC)) begin
        host_wait_pin_q <= 16'h0001 << hdr_q[64 + `RBL_FLAG_WAIT_LO +: 4];
      end
    end
  end

  // buffer and memory write from destination upward
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fb_d0_q    <= 8'h00;
      fb_d1_q    <= 8'h00;
      fb_n_q     <= 2'h0;
      mem_addr_q <= 32'h0;
      mem_data_q <= 8'h00;
      mem_we_q   <= 1'b0;
    end else begin
      if (mem_we_q && mem_ready) begin
        mem_we_q   <= 1'b0;
        mem_addr_q <= mem_addr_q + 32'h1;
      end
      // Destination is loaded only while a header arrives, so each block starts once
      if (st_q == ST_HDR) begin
        mem_addr_q <= hdr_q[39:8];
      end
      if (fb_pop) begin
        mem_data_q <= fb_d0_q;
        mem_we_q   <= 1'b1;
        fb_d0_q    <= fb_d1_q;
      end
      if (fb_push && !fb_full) begin
        if ((fb_n_q == 2'h0) || (fb_n_q == 2'h1 && fb_pop)) fb_d0_q <= got_byte_q;
        else fb_d1_q <= got_byte_q;
      end
      fb_n_q <= fb_n_q + {1'b0, fb_push && !fb_full} - {1'b0, fb_pop};
    end
  end

endmodule

// ---- testbench/rbl_host.sv ----
// SPI host model that streams a loader image into the slave port
`timescale 1ns/10ps
module rbl_host #(
  parameter [95:0] IMG = 96'h0
) (
  // Control
  input  wire        go,
  input  wire [15:0] wait_pins,
  // SPI pins
  output reg         ssck,
  output reg         ssel_n,
  output reg         smosi
);
  integer i;
  integer b;
  // Idle: clock low, deselected
  initial begin
    ssck = 1'b0;
    ssel_n = 1'b1;
    smosi = 1'b0;
  end
  always @(posedge go) begin
    ssel_n = 1'b0;
    for (i = 0; i < 12; i = i + 1) begin
      while (wait_pins[3] !== 1'b0)
        #80;
      for (b = 7; b >= 0; b = b - 1) begin
        smosi = IMG[88-8*i+b];
        #80 ssck = 1'b1;
        #80 ssck = 1'b0;
      end
    end
    #80 ssel_n = 1'b1;
    smosi = ~smosi;
  end
endmodule

// ---- testbench/rbl_chk.sv ----
// Port checker for the boot sequencer
`timescale 1ns/10ps
module rbl_chk (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Boot control
  input wire        por_event,
  input wire        sw_reset,
  input wire        hib_wake,
  input wire [1:0]  boot_select_pins,
  // Memory sides
  input wire [31:0] pf_addr_q,
  input wire        pf_rd_q,
  input wire        pf_ack,
  input wire        serial_memory_select_flag_q,
  input wire [15:0] host_wait_pin_q,
  input wire [31:0] mem_addr_q,
  input wire [7:0]  mem_data_q,
  input wire        mem_we_q,
  input wire        mem_ready,
  // Status
  input wire [31:0] fetch_addr_q,
  input wire        fetch_go_q,
  input wire [3:0]  amc_setup_q,
  input wire [3:0]  amc_access_q,
  input wire [3:0]  amc_hold_q,
  input wire [4:0]  reset_cfg_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Boot request with settled mode pins
  sequence s_ext_req;
    (boot_select_pins == 2'h0)[*3] ##0 (por_event || hib_wake);
  endsequence
  sequence s_ext_run;
    fetch_go_q && fetch_addr_q == 32'h20000000;
  endsequence
  sequence s_skip_run;
    fetch_go_q && fetch_addr_q == 32'h00010000;
  endsequence
  chk_amc_timing: assert property (amc_setup_q == 4'h4 && amc_access_q == 4'hF
    && amc_hold_q == 4'h3) else $error("memory timing not slowest");
  chk_ext_start: assert property (s_ext_req |-> ##[1:20] s_ext_run)
    else $error("external run start wrong");
  chk_skip_boot: assert property (reset_cfg_q[4] && sw_reset |-> ##[1:20] s_skip_run)
    else $error("boot skip start wrong");
  chk_go_addr: assert property ($rose(fetch_go_q) && !reset_cfg_q[4] |->
    fetch_addr_q == (reset_cfg_q[1:0] == 2'h0 ? 32'h20000000 : 32'h00010000))
    else $error("start address wrong");
  chk_mem_hold: assert property (mem_we_q && !mem_ready |=> mem_we_q
    && $stable(mem_addr_q) && $stable(mem_data_q)) else $error("memory write dropped");
  chk_pf_hold: assert property (pf_rd_q && !pf_ack |=> pf_rd_q && $stable(pf_addr_q))
    else $error("flash read dropped");
  chk_pf_bank: assert property (pf_rd_q |-> pf_addr_q[31:16] == 16'h2000
    && reset_cfg_q[1:0] == 2'h1) else $error("flash read outside bank");
  chk_sel_mode: assert property (!serial_memory_select_flag_q |->
    reset_cfg_q[1:0] == 2'h3) else $error("serial select in wrong mode");
  chk_wait_pin: assert property ($onehot0(host_wait_pin_q) &&
    (host_wait_pin_q == 16'h0 || reset_cfg_q[1:0] == 2'h2)) else $error("wait pin wrong");
endmodule

bind rbl_sequencer rbl_chk i_rbl_chk (.*);

// ---- testbench/rbl_sequencer_tb_top.sv ----
// Self-checking bench for the boot sequencer
`timescale 1ns/10ps
module rbl_sequencer_tb_top;
  localparam [95:0] IMG  = 96'h00000100020000006080A53C;
  localparam [31:0] IMEM = 32'h00010000;
  localparam [103:0] SROM = {8'h5A, IMG};
  reg         clk;
  reg         rst;
  reg  [3:0]  ev;
  reg  [1:0]  pins;
  reg         hgo;
  reg  [7:0]  pf_data;
  reg         pf_ack;
  reg         mem_ready;
  reg         seen_sel;
  reg  [31:0] wa [0:3];
  reg  [7:0]  wd [0:3];
  integer     wn;
  reg         sm_on;
  reg  [7:0]  sm_cmd;
  integer     sm_b;
  wire        miso, msck_q, mosi_q;
  integer     err_count;
  integer     checks;
  wire [31:0] pf_addr_q, mem_addr_q, fetch_addr_q;
  wire [15:0] host_wait_pin_q;
  wire [7:0]  mem_data_q;
  wire [4:0]  reset_cfg_q;
  wire [3:0]  amc_setup_q, amc_access_q, amc_hold_q;
  wire        pf_rd_q, serial_memory_select_flag_q, mem_we_q, fetch_go_q, ext_pack16_q;
  wire        boot_busy_q, spi_fail_q, ssck, ssel_n, smosi;
  rbl_sequencer i_rbl_sequencer (.clk, .rst, .por_event(ev[0]), .sw_reset(ev[1]),
    .hib_wake(ev[2]), .boot_select_pins(pins), .cfg_noboot_set(ev[3]), .pf_addr_q,
    .pf_rd_q, .pf_data, .pf_ack, .serial_memory_select_flag_q, .msck_q, .mosi_q,
    .miso, .ssck, .ssel_n, .smosi, .host_wait_pin_q, .mem_addr_q, .mem_data_q,
    .mem_we_q, .mem_ready, .fetch_addr_q, .fetch_go_q, .ext_pack16_q, .amc_setup_q,
    .amc_access_q, .amc_hold_q, .reset_cfg_q, .boot_busy_q, .spi_fail_q);
  rbl_host #(.IMG(IMG)) i_rbl_host (.go(hgo), .wait_pins(host_wait_pin_q), .ssck,
    .ssel_n, .smosi);
  // Serial memory partner, 8-bit address: two ones bytes, a marker, then the image
  // reply moves after each falling clock, released line reads high
  assign miso = (!sm_on || sm_b < 16 || sm_b > 119) ? 1'b1 : SROM[119 - sm_b];
  always @(negedge msck_q or posedge serial_memory_select_flag_q) begin
    if (serial_memory_select_flag_q)
      sm_b <= 0;
    else
      sm_b <= sm_b + 1;
  end
  // Command byte as seen on mosi at the rising clock
  always @(posedge msck_q) begin
    if (sm_b < 8)
      sm_cmd <= {sm_cmd[6:0], mosi_q};
  end
  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Flash and memory responders, select monitor
  always @(negedge clk) begin
    pf_ack <= pf_rd_q && !pf_ack;
    pf_data <= pf_rd_q ? IMG[95-8*pf_addr_q[3:0] -: 8] : ~pf_data;
    mem_ready <= mem_we_q && !mem_ready;
    if (mem_we_q && !mem_ready) begin
      wa[wn[1:0]] <= mem_addr_q;
      wd[wn[1:0]] <= mem_data_q;
      wn <= wn + 1;
    end
    if (serial_memory_select_flag_q === 1'b0)
      seen_sel <= 1'b1;
  end
  task chk(input string nm, input [31:0] e, input [31:0] g);
    checks++;
    if (e !== g) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task do_rst(input integer n);
    rst = 1'b1;
    hgo = 1'b0;
    wn = 0;
    seen_sel = 1'b0;
    repeat (n) @(negedge clk);
    rst = 1'b0;
  endtask
  task boot(input [1:0] m, input [3:0] e);
    @(negedge clk) pins = m;
    repeat (3) @(negedge clk);
    ev = e;
    @(negedge clk) ev = 4'h0;
  endtask
  task wait_done(input integer n);
    integer c;
    c = 0;
    while (fetch_go_q !== 1'b1 && spi_fail_q !== 1'b1 && c < n) begin
      @(negedge clk);
      c++;
    end
    chk("done", 1, c < n);
  endtask
  task chk_load(input [1:0] m);
    chk("words", 2, wn);                  // header count
    chk("addr0", IMEM, wa[0]);            // lowest address
    chk("data0", 8'hA5, wd[0]);           // payload order
    chk("addr1", IMEM + 1, wa[1]);        // arrival order
    chk("data1", 8'h3C, wd[1]);           // arrival order
    chk("start", IMEM, fetch_addr_q);     // run after load
    chk("mode", m, reset_cfg_q[1:0]);     // mode decode
    chk("idle", 0, boot_busy_q);          // busy ends at run
  endtask
  task give_verdict;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #1000000;
    err_count++;
    give_verdict;
  end
  // Tests
  initial begin
    {ev, pins, pf_data, pf_ack, mem_ready, sm_on} = 0;
    sm_b = 0;
    err_count = 0;
    checks = 0;
    do_rst(20);
    chk("amc", 12'h4F3, {amc_setup_q, amc_access_q, amc_hold_q}); // reset timing
    boot(2'h0, 4'h1);
    wait_done(100);
    chk("ext", 32'h20000000, fetch_addr_q); // external start
    chk("pack", 1, ext_pack16_q);           // sixteen bit
    chk("mode", 0, reset_cfg_q[1:0]);       // mode capture
    $display("test ext done");
    do_rst(3);
    boot(2'h1, 4'h1);
    chk("busy", 1, boot_busy_q);            // busy while loading
    wait_done(5000);
    chk_load(2'h1);                         // flash load
    $display("test flash done");
    do_rst(3);
    boot(2'h2, 4'h1);
    hgo = 1'b1;
    wait_done(5000);
    chk_load(2'h2);                         // host load
    $display("test host done");
    do_rst(3);
    boot(2'h2, 4'h8);
    chk("cfg4", 1, reset_cfg_q[4]);         // skip flag
    boot(2'h2, 4'h2);
    wait_done(100);
    chk("skip", IMEM, fetch_addr_q);        // direct jump
    chk("noload", 0, wn);                   // no loading
    $display("test skip done");
    do_rst(3);
    boot(2'h0, 4'h4);
    wait_done(100);
    chk("wake", 32'h20000000, fetch_addr_q); // wake boots
    $display("test wake done");
    do_rst(3);
    sm_on = 1'b1;
    boot(2'h3, 4'h1);
    wait_done(5000);
    chk_load(2'h3);                         // serial load
    chk("cmd", 8'h03, sm_cmd);              // read command
    $display("test serial load done");
    do_rst(3);
    sm_on = 1'b0;
    boot(2'h3, 4'h1);
    wait_done(5000);
    chk("fail", 1, spi_fail_q);             // no device
    chk("sel", 1, seen_sel);                // select driven
    chk("nogo", 0, fetch_go_q);             // nothing run
    $display("test serial done");
    give_verdict;
  end
endmodule
